/* File: rtl/fsp_consts.svh */
// Offsets, field positions and reset values of the self-programming sequencer
//
// Overview of operation
// R1: Erase one page or program word pair
// R2: Stall processor until operation completes
// R3: Go bit 15 launches; hardware clears it
// R4: Program pair starts on every other word; the code requires address bits [1:0] to be 2'h2
// R5: Software erases page before programming it
// R6: Erase or program needs unlock key first
// R7: Key is 0x55 then 0xAA, consecutive
// R8: Key register is write-only, reads zero
// R9: High and low address form 24-bit address
// R10: Software puts two no-ops after start
// R11: Go without fresh key is ignored
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// ****************************************************************
// Register byte offsets (low address bits)
// ****************************************************************
`define FSP_OFS_CTRL      8'h00
`define FSP_OFS_KEY       8'h04
`define FSP_OFS_ADDR_HIGH 8'h08
`define FSP_OFS_ADDR_LOW  8'h0C
`define FSP_OFS_DATA0     8'h10
`define FSP_OFS_DATA1     8'h14

// ****************************************************************
// Control register fields
// ****************************************************************
`define FSP_CTRL_GO_BIT   15
`define FSP_CTRL_BUSY_BIT 14
`define FSP_CTRL_ERR_BIT  13
`define FSP_CTRL_OP_BIT   0

// ****************************************************************
// Key values, alignment and reset values
// ****************************************************************
`define FSP_KEY_FIRST     8'h55
`define FSP_KEY_SECOND    8'hAA
`define FSP_PAIR_ALIGN    2'h2
`define FSP_RST_ADDR_HIGH 8'h00
`define FSP_RST_ADDR_LOW  16'h0000
`define FSP_RST_DATA      24'h000000

`endif

/* File: rtl/fsp_pkg.sv */
// Types shared by the self-programming sequencer modules
`default_nettype none
package fsp_pkg;
    // Operation selected by software
    typedef enum logic {
        FSP_OP_PROGRAM = 1'b0,
        FSP_OP_ERASE   = 1'b1
    } fsp_op_e;

    // Unlock key progress
    typedef enum logic [1:0] {
        FSP_KEY_IDLE  = 2'b00,
        FSP_KEY_GOT1  = 2'b01,
        FSP_KEY_ARMED = 2'b10
    } fsp_key_e;

    // Engine state
    typedef enum logic {
        FSP_ENG_IDLE = 1'b0,
        FSP_ENG_RUN  = 1'b1
    } fsp_eng_e;

    // Command handed to the flash array
    typedef struct packed {
        fsp_op_e     op;
        logic [23:0] addr;
        logic [23:0] data0;
        logic [23:0] data1;
    } fsp_flash_cmd_s;
endpackage
`default_nettype wire

/* File: rtl/fsp_flash_engine.sv */
// Operation engine: drives the flash array and stalls the core
`default_nettype none
module fsp_flash_engine
    import fsp_pkg::*;
(
    // Clock and reset
    input  wire logic     sys_clk,
    input  wire logic     rst,
    // Launch from register file
    input  wire logic     start,
    input  wire fsp_flash_cmd_s cmd_in,
    // Flash array handshake
    input  wire logic     flash_done,
    output logic          flash_req,
    output fsp_flash_cmd_s flash_cmd,
    // Core stall and completion
    output logic          cpu_stall,
    output logic          done
);
    // ****************************************************************
    // State
    // ****************************************************************
    fsp_eng_e       state_reg, state_next;   // Engine state
    logic           req_reg, req_next;       // Request to array
    logic           stall_reg, stall_next;   // Core stall
    logic           done_reg, done_next;     // Completion pulse
    fsp_flash_cmd_s cmd_reg, cmd_next;       // Captured command

    // Next-state logic
    always_comb begin
        state_next = state_reg;
        req_next   = req_reg;
        stall_next = stall_reg;
        done_next  = 1'b0;
        cmd_next   = cmd_reg;
        unique case (state_reg)
            FSP_ENG_IDLE: begin
                // Capture command and hold the core (see R2)
                if (start) begin
                    state_next = FSP_ENG_RUN;
                    cmd_next   = cmd_in;
                    req_next   = 1'b1;
                    stall_next = 1'b1;   // see R2
                end
            end
            FSP_ENG_RUN: begin
                // Release only when the array reports finish
                if (flash_done) begin
                    state_next = FSP_ENG_IDLE;
                    req_next   = 1'b0;
                    stall_next = 1'b0;   // see R2
                    done_next  = 1'b1;   // see R3
                end
            end
        endcase
    end

    // Registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= FSP_ENG_IDLE;
            req_reg   <= 1'b0;
            stall_reg <= 1'b0;
            done_reg  <= 1'b0;
            cmd_reg   <= '0;
        end else begin
            state_reg <= state_next;
            req_reg   <= req_next;
            stall_reg <= stall_next;
            done_reg  <= done_next;
            cmd_reg   <= cmd_next;
        end
    end

    assign flash_req = req_reg;
    assign flash_cmd = cmd_reg;
    assign cpu_stall = stall_reg;
    assign done      = done_reg;
endmodule
`default_nettype wire

/* File: rtl/fsp_sequencer.sv */
// Self-programming sequencer top: AHB-Lite registers, key and launch
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`include "fsp_consts.svh"
`default_nettype none
module fsp_sequencer
    import fsp_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Flash array side
    output logic             flash_req,
    output fsp_flash_cmd_s   flash_cmd,
    input  wire logic        flash_done,
    // Processor core
    output logic             cpu_stall
);
    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Program pairs start only at addresses whose low two bits are 2'h2
    function automatic logic pair_aligned(input logic [23:0] a);
        pair_aligned = (a[1:0] == `FSP_PAIR_ALIGN);   // see R4
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic           ap_valid;                    // Address phase taken
    logic           wr_pend_reg, wr_pend_next;   // Write data phase
    logic           rd_pend_reg, rd_pend_next;   // Read wait state
    logic [7:0]     ofs_reg, ofs_next;           // Latched offset
    logic           hready_reg, hready_next;     // Ready to bus
    logic [31:0]    hrdata_reg, hrdata_next;     // Read data
    logic           go_reg, go_next;             // Go bit
    logic           err_reg, err_next;           // Refused launch
    fsp_op_e        op_reg, op_next;             // Selected op
    logic [7:0]     addr_hi_reg, addr_hi_next;   // Upper address
    logic [15:0]    addr_lo_reg, addr_lo_next;   // Lower address
    logic [23:0]    data0_reg, data0_next;       // First word
    logic [23:0]    data1_reg, data1_next;       // Second word
    fsp_key_e       key_reg, key_next;           // Unlock progress
    logic           launch_reg, launch_next;     // Start pulse
    logic [23:0]    eff_addr;                    // Target address
    fsp_flash_cmd_s cmd_in;                      // Command to engine
    fsp_op_e        wr_op;                       // Op in write data
    logic           eng_done;                    // Engine finished
    logic [31:0]    rd_mux;                      // Read selection

    // Effective target address from the two halves (see R9)
    assign eff_addr = {addr_hi_reg, addr_lo_reg};
    assign ap_valid = hsel & htrans[1] & hready;
    assign wr_op    = fsp_op_e'(hwdata[`FSP_CTRL_OP_BIT]);
    assign cmd_in   = '{op: op_reg, addr: eff_addr,
                        data0: data0_reg, data1: data1_reg};

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************

    // Select register contents; key reads as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (ofs_reg)
            `FSP_OFS_CTRL: begin
                rd_mux[`FSP_CTRL_GO_BIT]   = go_reg;
                rd_mux[`FSP_CTRL_BUSY_BIT] = cpu_stall;
                rd_mux[`FSP_CTRL_ERR_BIT]  = err_reg;
                rd_mux[`FSP_CTRL_OP_BIT]   = op_reg;
            end
            `FSP_OFS_KEY:       rd_mux = 32'h0000_0000;   // see R8
            `FSP_OFS_ADDR_HIGH: rd_mux = {24'h00_0000, addr_hi_reg};
            `FSP_OFS_ADDR_LOW:  rd_mux = {16'h0000, addr_lo_reg};
            `FSP_OFS_DATA0:     rd_mux = {8'h00, data0_reg};
            `FSP_OFS_DATA1:     rd_mux = {8'h00, data1_reg};
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Bus phase tracking
    // ****************************************************************

    // Reads take one wait state so earlier writes are seen
    always_comb begin
        wr_pend_next = ap_valid & hwrite;
        rd_pend_next = ap_valid & ~hwrite;
        ofs_next     = ap_valid ? haddr[7:0] : ofs_reg;
        hready_next  = ~(ap_valid & ~hwrite);
        hrdata_next  = hrdata_reg;
        // Wait state: capture the read data
        if (rd_pend_reg) begin
            hrdata_next = rd_mux;
        end
    end

    // ****************************************************************
    // Register file, key sequence and launch
    // ****************************************************************

    // Writes land in the data phase; hardware clears go on finish
    always_comb begin
        go_next      = go_reg;
        err_next     = err_reg;
        op_next      = op_reg;
        addr_hi_next = addr_hi_reg;
        addr_lo_next = addr_lo_reg;
        data0_next   = data0_reg;
        data1_next   = data1_reg;
        key_next     = key_reg;
        launch_next  = 1'b0;
        // Operation finished: drop go (see R3)
        if (eng_done) begin
            go_next = 1'b0;   // see R3
        end
        if (wr_pend_reg) begin
            // Any write other than the key breaks the sequence
            key_next = FSP_KEY_IDLE;   // see R7
            unique case (ofs_reg)
                `FSP_OFS_KEY: begin
                    // Track 0x55 then 0xAA as consecutive writes
                    if (hwdata[7:0] == `FSP_KEY_FIRST) begin
                        key_next = FSP_KEY_GOT1;   // see R7
                    end else if (hwdata[7:0] == `FSP_KEY_SECOND
                                 && key_reg == FSP_KEY_GOT1) begin
                        key_next = FSP_KEY_ARMED;   // see R6
                    end
                end
                `FSP_OFS_CTRL: begin
                    // Writes while an operation runs are ignored
                    if (!go_reg) begin
                        op_next = wr_op;   // see R1
                        if (hwdata[`FSP_CTRL_GO_BIT]) begin
                            // Launch only when armed and, for a program pair, aligned
                            if (key_reg == FSP_KEY_ARMED
                                && (wr_op == FSP_OP_ERASE
                                    || pair_aligned(eff_addr))) begin
                                go_next     = 1'b1;   // see R3
                                launch_next = 1'b1;   // see R6
                                err_next    = 1'b0;
                            end else begin
                                // Refused: go stays clear (see R11)
                                err_next = 1'b1;   // see R4
                            end
                        end
                    end
                end
                `FSP_OFS_ADDR_HIGH: begin
                    if (!go_reg) begin
                        addr_hi_next = hwdata[7:0];   // see R9
                    end
                end
                `FSP_OFS_ADDR_LOW: begin
                    if (!go_reg) begin
                        addr_lo_next = hwdata[15:0];   // see R9
                    end
                end
                `FSP_OFS_DATA0: begin
                    if (!go_reg) begin
                        data0_next = hwdata[23:0];
                    end
                end
                `FSP_OFS_DATA1: begin
                    if (!go_reg) begin
                        data1_next = hwdata[23:0];
                    end
                end
                default: begin
                    // Unmapped: write dropped
                    key_next = FSP_KEY_IDLE;
                end
            endcase
        end
    end

    // Registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            ofs_reg     <= 8'h00;
            hready_reg  <= 1'b1;
            hrdata_reg  <= 32'h0000_0000;
            go_reg      <= 1'b0;
            err_reg     <= 1'b0;
            op_reg      <= FSP_OP_PROGRAM;
            addr_hi_reg <= `FSP_RST_ADDR_HIGH;
            addr_lo_reg <= `FSP_RST_ADDR_LOW;
            data0_reg   <= `FSP_RST_DATA;
            data1_reg   <= `FSP_RST_DATA;
            key_reg     <= FSP_KEY_IDLE;
            launch_reg  <= 1'b0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            ofs_reg     <= ofs_next;
            hready_reg  <= hready_next;
            hrdata_reg  <= hrdata_next;
            go_reg      <= go_next;
            err_reg     <= err_next;
            op_reg      <= op_next;
            addr_hi_reg <= addr_hi_next;
            addr_lo_reg <= addr_lo_next;
            data0_reg   <= data0_next;
            data1_reg   <= data1_next;
            key_reg     <= key_next;
            launch_reg  <= launch_next;
        end
    end

    // ****************************************************************
    // Operation engine
    // ****************************************************************

    // Runs the erase or pair program and holds the core (see R2)
    fsp_flash_engine u_engine (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .start      (launch_reg),
        .cmd_in     (cmd_in),
        .flash_done (flash_done),
        .flash_req  (flash_req),
        .flash_cmd  (flash_cmd),
        .cpu_stall  (cpu_stall),
        .done       (eng_done)
    );

    // Bus outputs straight from flops; response always OKAY
    assign hreadyout = hready_reg;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // hsize unused: only whole-word accesses are supported
    logic unused_hsize;
    assign unused_hsize = ^hsize;
endmodule
`default_nettype wire

/* File: verification/fsp_sequencer_sva.sv */
// Checker for the self-programming sequencer ports
`include "fsp_consts.svh"
`default_nettype none
module fsp_sequencer_chk
    import fsp_pkg::*;
(
    // Clock and reset
    input wire logic           sys_clk,
    input wire logic           rst,
    // Bus
    input wire logic           hsel,
    input wire logic [31:0]    haddr,
    input wire logic [1:0]     htrans,
    input wire logic           hwrite,
    input wire logic [31:0]    hwdata,
    input wire logic           hready,
    input wire logic           hreadyout,
    input wire logic [31:0]    hrdata,
    // Flash and core
    input wire logic           flash_req,
    input wire fsp_flash_cmd_s flash_cmd,
    input wire logic           flash_done,
    input wire logic           cpu_stall
);
    // ****************************************************************
    // Key tracking helper
    // ****************************************************************
    logic       rd_take, wr_take;     // Taken address phases
    logic       wp_reg, wp_next;      // Write data phase pending
    logic [7:0] wo_reg, wo_next;      // Its offset
    logic [1:0] ks_reg, ks_next;      // Key progress seen
    logic       ls_reg, ls_next;      // Keyed go write just landed
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign wr_take = hsel && htrans[1] && hready && hwrite;
    // Next values of the helper
    always_comb begin
        wp_next = wp_reg;
        wo_next = wo_reg;
        ks_next = ks_reg;
        ls_next = 1'b0;
        if (hready && wp_reg) begin
            ks_next = 2'h0;
            if (wo_reg == `FSP_OFS_KEY && hwdata[7:0] == `FSP_KEY_FIRST)
                ks_next = 2'h1;
            if (wo_reg == `FSP_OFS_KEY && hwdata[7:0] == `FSP_KEY_SECOND
                && ks_reg == 2'h1)
                ks_next = 2'h2;
            ls_next = wo_reg == `FSP_OFS_CTRL && ks_reg == 2'h2
                      && hwdata[`FSP_CTRL_GO_BIT];
        end
        if (hready) begin
            wp_next = wr_take;
            wo_next = haddr[7:0];
        end
    end
    // Register the helper
    always_ff @(posedge sys_clk) begin
        wp_reg <= rst ? 1'b0 : wp_next;
        wo_reg <= wo_next;
        ks_reg <= rst ? 2'h0 : ks_next;
        ls_reg <= rst ? 1'b0 : ls_next;
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_stall_req: assert property (
        cpu_stall == flash_req) else $error("stall differs from request");
    chk_done_ends: assert property (
        flash_req && flash_done |=> !flash_req && !cpu_stall)
        else $error("operation did not end on done");
    chk_cmd_held: assert property (
        flash_req && $past(flash_req) |-> $stable(flash_cmd))
        else $error("command changed during operation");
    chk_pair_align: assert property (
        $rose(flash_req) && flash_cmd.op == FSP_OP_PROGRAM
        |-> flash_cmd.addr[1:0] == `FSP_PAIR_ALIGN)
        else $error("misaligned pair launched");
    chk_key_first: assert property (
        $rose(flash_req) |-> $past(ls_reg)) else $error("launch without key");
    chk_rd_wait: assert property (
        rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    chk_key_reads: assert property (
        rd_take && haddr[7:0] == `FSP_OFS_KEY |=> ##1 hrdata == 32'h0)
        else $error("key register readable");
    chk_wr_nowait: assert property (
        wr_take |=> hreadyout) else $error("write stalled");
endmodule
bind fsp_sequencer fsp_sequencer_chk u_chk (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .flash_req(flash_req), .flash_cmd(flash_cmd),
    .flash_done(flash_done), .cpu_stall(cpu_stall));
`default_nettype wire

/* File: verification/fsp_flash_sim.sv */
// Flash array model answering the sequencer's requests
`default_nettype none
module fsp_flash_sim (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // Request and answer
    input wire logic       flash_req,
    input wire logic [7:0] dly,
    output logic           flash_done
);
    logic [7:0] cnt_reg;  // Cycles spent on the current operation
    // Count while a request stands, clear between operations
    always_ff @(posedge sys_clk) begin
        cnt_reg <= (rst || !flash_req) ? 8'h00 : cnt_reg + 8'h01;
    end
    // Done once the chosen busy time has passed
    assign flash_done = flash_req && cnt_reg == dly;
endmodule
`default_nettype wire

/* File: verification/flash_self_program_sequencer_tb_top.sv */
// Testbench for the self-programming sequencer
`include "fsp_consts.svh"
`default_nettype none
module flash_self_program_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fsp_pkg::*;
    logic sys_clk, rst, hsel, hwrite, hreadyout, flash_req, flash_done;
    logic cpu_stall, rd_dp, req_d, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] dly;
    logic [23:0] a, d0, d1;
    fsp_flash_cmd_s flash_cmd;
    logic [31:0] rq[$];      // Expected read data
    fsp_flash_cmd_s cq[$];   // Expected flash commands
    int err_total, checks;
    fsp_sequencer uut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .flash_req(flash_req),
        .flash_cmd(flash_cmd), .flash_done(flash_done),
        .cpu_stall(cpu_stall));
    fsp_flash_sim u_flash (.sys_clk(sys_clk), .rst(rst),
        .flash_req(flash_req), .dly(dly), .flash_done(flash_done));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Compare one result
    task automatic cmp(input logic [72:0] got, input logic [72:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Monitor: read data and launched commands against the notes
    always @(posedge sys_clk) begin
        if (rd_dp && hreadyout)
            cmp(hrdata, rq.size() ? rq.pop_front() : 'x);
        if (flash_req && !req_d)
            cmp(flash_cmd, cq.size() ? cq.pop_front() : 'x);
        rd_dp = rst ? 1'b0 : (hreadyout ? hsel && htrans[1] && !hwrite : rd_dp);
        req_d = flash_req;
    end
    // Wait for ready, bounded; running out or an error response is a miss
    task automatic wt;
        @(posedge sys_clk);
        for (int i = 0; i < 50 && hreadyout !== 1'b1; i++) @(posedge sys_clk);
        cmp({hresp, hreadyout}, 2'b01);
    endtask
    // One single bus transfer
    task automatic ahb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, ad};
        hwrite <= w;
        wt();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h0;
        wt();
    endtask
    // Read with its expected value queued
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        rq.push_back(e);
        ahb(1'b0, ad, 32'h0);
    endtask
    // Full operation; brk spoils the key sequence in various ways
    task automatic op(input logic er, input logic [23:0] ad,
                      input logic [7:0] dl, input int brk);
        logic ok;
        ok = brk == 0 && (er || ad[1:0] == `FSP_PAIR_ALIGN);
        d0 = 24'($urandom);
        d1 = 24'($urandom);
        dly <= dl;
        ahb(1'b1, `FSP_OFS_ADDR_HIGH, {24'h0, ad[23:16]});
        ahb(1'b1, `FSP_OFS_ADDR_LOW, {16'h0, ad[15:0]});
        ahb(1'b1, `FSP_OFS_DATA0, {8'h0, d0});
        ahb(1'b1, `FSP_OFS_DATA1, {8'h0, d1});
        if (brk != 1 && brk != 3) ahb(1'b1, `FSP_OFS_KEY, 32'h55);
        if (brk == 2) ahb(1'b1, `FSP_OFS_ADDR_LOW, {16'h0, ad[15:0]});
        if (brk != 1) ahb(1'b1, `FSP_OFS_KEY, 32'hAA);
        if (brk == 3) ahb(1'b1, `FSP_OFS_KEY, 32'h55);
        if (ok) cq.push_back(fsp_flash_cmd_s'({er, ad, d0, d1}));
        ahb(1'b1, `FSP_OFS_CTRL, {16'h0, 1'b1, 14'h0, er});
        if (!ok) rd(`FSP_OFS_CTRL, {16'h0, 3'b001, 12'h0, er});
        else if (dl > 8'h4)
            rd(`FSP_OFS_CTRL, {16'h0, 3'b110, 12'h0, er});
        // Two idle slots after the start, as software must leave them
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 300 && cpu_stall !== 1'b0; i++) @(posedge sys_clk);
        cmp(cpu_stall, 1'b0);
        repeat (2) @(posedge sys_clk);
        if (ok) rd(`FSP_OFS_CTRL, {16'h0, 15'h0, er});
        $display("test op %0d brk %0d done", er, brk);
    endtask
    // Closing task
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog, far beyond the expected run
    initial begin
        #400000;
        err_total++;
        give_verdict();
    end
    // Main sequence
    initial begin
        logic [31:0] r, m;
        rst = 1'b1;
        {hsel, hwrite, rd_dp, req_d} = 4'h0;
        {haddr, hwdata} = 64'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        dly = 8'h00;
        err_total = 0;
        checks = 0;
        void'($urandom(58759));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0);
        $display("test reset values done");
        for (int i = 1; i < 7; i++) begin
            r = $urandom;
            m = i == 2 ? 32'hFF : i == 3 ? 32'hFFFF : 32'hFFFFFF;
            if (i == 1 || i == 6) m = 32'h0;
            ahb(1'b1, 8'(i * 4), r);
            rd(8'(i * 4), r & m);
        end
        $display("test register access done");
        a = 24'($urandom);
        op(1'b1, a, 8'd20, 0);
        op(1'b0, {a[23:2], 2'b10}, 8'd0, 0);
        for (int b = 1; b < 4; b++)
            op(1'b0, {a[23:2], 2'b10}, 8'd3, b);
        op(1'b0, {a[23:2], 2'b01}, 8'd3, 0);
        repeat (2) @(posedge sys_clk);
        cmp(rq.size() + cq.size(), 0);
        give_verdict();
    end
endmodule
`default_nettype wire
